/* hdl/oemc_top.sv */
// Command decode and on/off control for converter output enable and margining.
//
// How it works
// - Enable 00 turns off immediately, no sequencing
// - Enable 01 soft off; 10 on at margin
// - Margin field picks nominal, low or high
// - Ignore mode masks voltage faults while margined
// - Act mode passes voltage faults while margined
// - Power-up bit 0: run whenever power present
// - Power-up bit 1: wait for pin and/or command, as the bus and pin-use bits select
// - Bus bit 0 ignores command on/off part
// - Bus bit 1 requires command to request run
// - Pin-use bit decides whether pin gates start
// - Polarity bit sets pin active level
// - Pin off with bit0=0 uses soft off
// - Pin off with bit0=1 turns off immediately
// - Clear-faults command resets all fault bits
`timescale 1ns/100ps
`include "oemc_params.svh"
module oemc_top
  import oemc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [7:0] wr_cmd,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_cmd,
  input wire logic power_ok,
  input wire logic remote_pin,
  input wire logic soft_off_done,
  input wire logic fault_in,
  input wire logic vfault_in,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic out_run,
  output logic out_soft_off,
  output logic out_imm_off,
  output logic [1:0] out_margin,
  output logic mask_vfault,
  output logic fault_sticky,
  output logic vfault_sticky
);
  logic [7:0] run_r, run_nxt;
  logic [7:0] src_r, src_nxt;
  logic [1:0] pin_sync_r;
  logic pin_r;
  oemc_state_t st_r, st_nxt;
  oemc_out_t out_r, out_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic flt_r, flt_nxt, vflt_r, vflt_nxt;
  oemc_run_t run_f;
  logic pin_act, want_on, want_off, off_imm, margined;

  // Reserved codes in a write are dropped field by field so the old setting stays.
  always_comb begin
    run_nxt = run_r;
    src_nxt = src_r;
    if (wr_en && wr_cmd == `OEMC_CMD_RUN) begin
      if (wr_data[`OEMC_EN_HI:`OEMC_EN_LO] != `OEMC_CODE_RSV) begin
        run_nxt[`OEMC_EN_HI:`OEMC_EN_LO] = wr_data[`OEMC_EN_HI:`OEMC_EN_LO];
      end
      if (wr_data[`OEMC_MG_HI:`OEMC_MG_LO] != `OEMC_CODE_RSV) begin
        run_nxt[`OEMC_MG_HI:`OEMC_MG_LO] = wr_data[`OEMC_MG_HI:`OEMC_MG_LO];
      end
      if (wr_data[`OEMC_FH_HI:`OEMC_FH_LO] == `OEMC_FH_IGN ||
          wr_data[`OEMC_FH_HI:`OEMC_FH_LO] == `OEMC_FH_ACT) begin
        run_nxt[`OEMC_FH_HI:`OEMC_FH_LO] = wr_data[`OEMC_FH_HI:`OEMC_FH_LO];
      end
    end
    if (wr_en && wr_cmd == `OEMC_CMD_SRC) begin
      src_nxt = {3'h0, wr_data[`OEMC_SRC_PWRUP:`OEMC_SRC_IMM]};
    end
  end

  assign run_f = '{en: run_r[`OEMC_EN_HI:`OEMC_EN_LO], margin: run_r[`OEMC_MG_HI:`OEMC_MG_LO],
                   fault: run_r[`OEMC_FH_HI:`OEMC_FH_LO]};

  // Pin polarity: active when level matches the polarity bit.
  assign pin_act = (pin_r == src_r[`OEMC_SRC_POL]);

  // Run request from the configured start sources.
  always_comb begin
    if (!src_r[`OEMC_SRC_PWRUP]) begin
      want_on = power_ok;
    end else begin
      want_on = power_ok && (run_f.en == `OEMC_EN_ON || !src_r[`OEMC_SRC_BUS])
                && (pin_act || !src_r[`OEMC_SRC_PIN]);
    end
  end

  // Decide how a stop is carried out: command code or pin disable action.
  always_comb begin
    off_imm = !power_ok;
    if (src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_BUS] && run_f.en == `OEMC_EN_IMM) begin
      off_imm = 1'b1;
    end
    if (src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_PIN] && !pin_act && src_r[`OEMC_SRC_IMM]) begin
      off_imm = 1'b1;
    end
  end
  assign want_off = !want_on;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      OEMC_OFF: begin
        if (want_on) begin
          st_nxt = OEMC_ON;
        end
      end
      OEMC_ON: begin
        if (want_off) begin
          st_nxt = off_imm ? OEMC_OFF : OEMC_SOFT_OFF;
        end
      end
      OEMC_SOFT_OFF: begin
        if (off_imm || soft_off_done) begin
          st_nxt = OEMC_OFF;
        end else if (want_on) begin
          st_nxt = OEMC_ON;
        end
      end
      default: st_nxt = OEMC_OFF;
    endcase
  end

  assign margined = (run_f.margin != `OEMC_MG_NOM);

  always_comb begin
    out_nxt.run = (st_nxt == OEMC_ON);
    out_nxt.soft_off = (st_nxt == OEMC_SOFT_OFF);
    out_nxt.imm_off = (st_r != OEMC_OFF) && (st_nxt == OEMC_OFF) && off_imm;
    out_nxt.margin = run_f.margin;
    out_nxt.mask_vfault = margined && (run_f.fault == `OEMC_FH_IGN);
  end

  // Set beats clear so a fault in the clearing cycle is kept.
  always_comb begin
    flt_nxt = flt_r;
    vflt_nxt = vflt_r;
    if (wr_en && wr_cmd == `OEMC_CMD_CLR) begin
      flt_nxt = 1'b0;
      vflt_nxt = 1'b0;
    end
    if (fault_in) begin
      flt_nxt = 1'b1;
    end
    if (vfault_in && !out_r.mask_vfault) begin
      vflt_nxt = 1'b1;
    end
  end

  always_comb begin
    rd_valid_nxt = rd_en;
    case (rd_cmd)
      `OEMC_CMD_RUN: rd_data_nxt = run_r;
      `OEMC_CMD_SRC: rd_data_nxt = src_r;
      default: rd_data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_r <= `OEMC_RUN_RST;
      src_r <= `OEMC_SRC_RST;
      pin_sync_r <= 2'h0;
      pin_r <= 1'b0;
      st_r <= OEMC_OFF;
      out_r <= '0;
      flt_r <= 1'b0;
      vflt_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      run_r <= run_nxt;
      src_r <= src_nxt;
      pin_sync_r <= {pin_sync_r[0], remote_pin};
      pin_r <= pin_sync_r[1];
      st_r <= st_nxt;
      out_r <= out_nxt;
      flt_r <= flt_nxt;
      vflt_r <= vflt_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign out_run = out_r.run;
  assign out_soft_off = out_r.soft_off;
  assign out_imm_off = out_r.imm_off;
  assign out_margin = out_r.margin;
  assign mask_vfault = out_r.mask_vfault;
  assign fault_sticky = flt_r;
  assign vfault_sticky = vflt_r;

  a_imm_off_cmd: assert property (@(posedge clk) disable iff (!nrst)
    (ce && st_r == OEMC_ON && src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_BUS] && run_f.en == `OEMC_EN_IMM)
    |=> (st_r == OEMC_OFF))
    else $error("immediate off did not reach off");
  a_soft_off_seq: assert property (@(posedge clk) disable iff (!nrst)
    (ce && st_r == OEMC_ON && want_off && !off_imm) |=> (st_r == OEMC_SOFT_OFF))
    else $error("soft off not sequenced");
  a_margin_out: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> (out_margin == $past(run_f.margin)))
    else $error("margin output wrong");
  a_mask_ignore: assert property (@(posedge clk) disable iff (!nrst)
    (mask_vfault && vfault_in && ce && !vflt_r && !(wr_en && wr_cmd == `OEMC_CMD_CLR)) |=> !vfault_sticky)
    else $error("masked fault latched");
  a_always_on: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !src_r[`OEMC_SRC_PWRUP] && power_ok && st_r == OEMC_OFF) |=> out_run)
    else $error("always-on did not start");
  a_bus_gate: assert property (@(posedge clk) disable iff (!nrst)
    (ce && src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_BUS] && run_f.en != `OEMC_EN_ON) |=> !out_run)
    else $error("ran without bus request");
  a_pin_gate: assert property (@(posedge clk) disable iff (!nrst)
    (ce && src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_PIN] && !pin_act) |=> !out_run)
    else $error("ran without pin");
  a_clear_faults: assert property (@(posedge clk) disable iff (!nrst)
    (ce && wr_en && wr_cmd == `OEMC_CMD_CLR && !fault_in) |=> !fault_sticky)
    else $error("clear faults failed");
  a_reserved_en: assert property (@(posedge clk) disable iff (!nrst)
    (ce && wr_en && wr_cmd == `OEMC_CMD_RUN && wr_data[`OEMC_EN_HI:`OEMC_EN_LO] == `OEMC_CODE_RSV)
    |=> $stable(run_r[`OEMC_EN_HI:`OEMC_EN_LO]))
    else $error("reserved enable code stored");

  // A pin stop is split into the trigger and the visible outcome, so each step can be read alone.
  sequence s_pin_drop;
    ce && st_r == OEMC_ON && power_ok && src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_PIN] && !pin_act
    && !src_r[`OEMC_SRC_IMM] && !(src_r[`OEMC_SRC_BUS] && run_f.en == `OEMC_EN_IMM);
  endsequence
  sequence s_soft_ramp;
    out_soft_off && !out_run && !out_imm_off;
  endsequence
  sequence s_pin_cut;
    ce && st_r != OEMC_OFF && src_r[`OEMC_SRC_PWRUP] && src_r[`OEMC_SRC_PIN] && !pin_act && src_r[`OEMC_SRC_IMM];
  endsequence
  sequence s_hard_stop;
    out_imm_off && !out_run && !out_soft_off;
  endsequence
  a_pin_soft_off: assert property (@(posedge clk) disable iff (!nrst)
    s_pin_drop |=> s_soft_ramp)
    else $error("pin soft off not sequenced");
  a_pin_cut_off: assert property (@(posedge clk) disable iff (!nrst)
    s_pin_cut |=> s_hard_stop)
    else $error("pin immediate off not taken");
endmodule

/* hdl/oemc_params.svh */
// Constants for the output enable and margin control block.
`ifndef OEMC_PARAMS_SVH
`define OEMC_PARAMS_SVH
`define OEMC_CMD_RUN 8'h01
`define OEMC_CMD_SRC 8'h02
`define OEMC_CMD_CLR 8'h03
`define OEMC_RUN_RST 8'h08
`define OEMC_SRC_RST 8'h17
`define OEMC_EN_HI 7
`define OEMC_EN_LO 6
`define OEMC_MG_HI 5
`define OEMC_MG_LO 4
`define OEMC_FH_HI 3
`define OEMC_FH_LO 2
`define OEMC_SRC_PWRUP 4
`define OEMC_SRC_BUS 3
`define OEMC_SRC_PIN 2
`define OEMC_SRC_POL 1
`define OEMC_SRC_IMM 0
`define OEMC_EN_IMM 2'h0
`define OEMC_EN_SOFT 2'h1
`define OEMC_EN_ON 2'h2
`define OEMC_MG_NOM 2'h0
`define OEMC_MG_LOW 2'h1
`define OEMC_MG_HIGH 2'h2
`define OEMC_FH_IGN 2'h1
`define OEMC_FH_ACT 2'h2
`define OEMC_CODE_RSV 2'h3
`endif

/* hdl/oemc_pkg.sv */
// Types for the output enable and margin control block.
package oemc_pkg;
  typedef enum logic [1:0] {OEMC_OFF, OEMC_SOFT_OFF, OEMC_ON} oemc_state_t;
  typedef struct packed {
    logic [1:0] en;
    logic [1:0] margin;
    logic [1:0] fault;
  } oemc_run_t;
  typedef struct packed {
    logic run;
    logic soft_off;
    logic imm_off;
    logic [1:0] margin;
    logic mask_vfault;
  } oemc_out_t;
endpackage

/* sim/oemc_far_model.sv */
// Far-side model: the output sequencer that ends a soft shutdown.
`timescale 1ns/100ps
module oemc_far_model (
  input wire logic clk,
  input wire logic out_soft_off,
  output logic soft_off_done
);
  logic [3:0] cnt_r;
  // The ramp takes a dozen cycles, so the bench can see the soft state first.
  always_ff @(posedge clk) begin
    cnt_r <= (out_soft_off === 1'b1) ? cnt_r + 4'h1 : 4'h0;
  end
  assign soft_off_done = (cnt_r == 4'hC);
endmodule

/* sim/oemc_top_tb_top.sv */
// Self-checking bench for the output enable and margin control block.
`timescale 1ns/100ps
module oemc_top_tb_top;
  import oemc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] wr_cmd = 8'h00, wr_data = 8'h00, rd_cmd = 8'h00, rd_data;
  logic power_ok = 1'b1, remote_pin = 1'b0, fault_in = 1'b0, vfault_in = 1'b0, soft_off_done;
  logic rd_valid, out_run, out_soft_off, out_imm_off, mask_vfault, fault_sticky, vfault_sticky;
  logic [1:0] out_margin;
  int failures = 0, checks_done = 0, cycles = 0, imm_cnt = 0;
  always #5 clk = ~clk;
  oemc_top uut (.clk(clk), .nrst(nrst), .ce(ce), .wr_en(wr_en), .wr_cmd(wr_cmd), .wr_data(wr_data),
    .rd_en(rd_en), .rd_cmd(rd_cmd), .power_ok(power_ok), .remote_pin(remote_pin),
    .soft_off_done(soft_off_done), .fault_in(fault_in), .vfault_in(vfault_in), .rd_data(rd_data),
    .rd_valid(rd_valid), .out_run(out_run), .out_soft_off(out_soft_off), .out_imm_off(out_imm_off),
    .out_margin(out_margin), .mask_vfault(mask_vfault), .fault_sticky(fault_sticky),
    .vfault_sticky(vfault_sticky));
  oemc_far_model far (.clk(clk), .out_soft_off(out_soft_off), .soft_off_done(soft_off_done));
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // The immediate-off output is a one-cycle pulse, so pulses are counted here and tasks compare counts.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (out_imm_off === 1'b1) imm_cnt <= imm_cnt + 1;
    if (cycles == 2500) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [4:0] exp);
    chk({3'h0, out_run, out_soft_off, out_margin, mask_vfault}, {3'h0, exp});
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_cmd = c;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    @(negedge clk);
    rd_en = 1'b1;
    rd_cmd = c;
    @(negedge clk);
    rd_en = 1'b0;
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask
  task automatic pin(input logic v);
    remote_pin = v;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_regs();
    rd(8'h01, 8'h08);
    rd(8'h02, 8'h17);
    rd(8'h05, 8'h00);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h1F);
    ce = 1'b0;
    wr(8'h02, 8'h00);
    ce = 1'b1;
    rd(8'h02, 8'h1F);
  endtask
  task automatic t_bus();
    int imm_base;
    wr(8'h02, 8'h18);
    wr(8'h01, 8'h88);
    st(5'b10000);
    wr(8'h01, 8'h98);
    st(5'b10010);
    wr(8'h01, 8'h94);
    st(5'b10011);
    wr(8'h01, 8'hA4);
    st(5'b10101);
    wr(8'h01, 8'hB4);
    wr(8'h01, 8'hE4);
    wr(8'h01, 8'hA0);
    st(5'b10101);
    wr(8'h01, 8'h88);
    imm_base = imm_cnt;
    wr(8'h01, 8'h08);
    st(5'b00000);
    chk(8'(imm_cnt - imm_base), 8'h01);
  endtask
  task automatic t_soft();
    int imm_base;
    wr(8'h01, 8'h88);
    imm_base = imm_cnt;
    wr(8'h01, 8'h48);
    chk({7'h00, out_soft_off}, 8'h01);
    repeat (16) @(negedge clk);
    st(5'b00000);
    chk(8'(imm_cnt - imm_base), 8'h00);
  endtask
  task automatic t_pin();
    int imm_base;
    wr(8'h02, 8'h1E);
    pin(1'b1);
    wr(8'h01, 8'h48);
    st(5'b00000);
    wr(8'h02, 8'h16);
    chk({7'h00, out_run}, 8'h01);
    pin(1'b0);
    chk({7'h00, out_soft_off}, 8'h01);
    repeat (16) @(negedge clk);
    wr(8'h02, 8'h15);
    chk({7'h00, out_run}, 8'h01);
    imm_base = imm_cnt;
    pin(1'b1);
    st(5'b00000);
    chk(8'(imm_cnt - imm_base), 8'h01);
  endtask
  task automatic t_always();
    wr(8'h02, 8'h00);
    pin(1'b0);
    chk({7'h00, out_run}, 8'h01);
    power_ok = 1'b0;
    repeat (20) @(negedge clk);
    chk({7'h00, out_run}, 8'h00);
    power_ok = 1'b1;
  endtask
  task automatic pulse(input logic f, input logic v);
    fault_in = f;
    vfault_in = v;
    @(negedge clk);
    fault_in = 1'b0;
    vfault_in = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_faults();
    wr(8'h01, 8'h94);
    pulse(1'b1, 1'b1);
    chk({6'h00, fault_sticky, vfault_sticky}, 8'h02);
    wr(8'h01, 8'h98);
    pulse(1'b0, 1'b1);
    chk({6'h00, fault_sticky, vfault_sticky}, 8'h03);
    wr(8'h03, 8'h00);
    chk({6'h00, fault_sticky, vfault_sticky}, 8'h00);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_bus();
    t_soft();
    t_pin();
    t_always();
    t_faults();
    stop_test();
  end
endmodule
